// File: rtl/dsq_cfg.svh
// Offsets, limits, function codes, reset values and timing counts of the step sequencer block
`ifndef DSQ_CFG_SVH
`define DSQ_CFG_SVH
`define DSQ_CLK_HZ         100000000
`define DSQ_TICK_MS        2
`define DSQ_TICK_CYC       ((`DSQ_CLK_HZ / 1000) * `DSQ_TICK_MS)
`define DSQ_DEB_MIN        5'h01
`define DSQ_DEB_MAX        5'h14
`define DSQ_DEB_RST        5'h01
`define DSQ_FREQ_MAX       16'h9C40
`define DSQ_GEAR_MIN       11'h004
`define DSQ_GEAR_MAX       11'h3E8
`define DSQ_GEAR_RST       11'h0C8
`define DSQ_ANGLE_MAX      12'hE10
`define DSQ_ANGLE_RST      12'h708
`define DSQ_IDXDEC_MAX     14'h2710
`define DSQ_STEP_TICKS_RST 16'h01F4
`define DSQ_OUT_RUNNING    6'h0A
`define DSQ_OUT_STEP_DONE  6'h0B
`define DSQ_OUT_PROG_DONE  6'h0C
`define DSQ_A_CTRL         4'h0
`define DSQ_A_TERMFN0      4'h1
`define DSQ_A_TERMFN1      4'h2
`define DSQ_A_MISC         4'h3
`define DSQ_A_INDEX        4'h4
`define DSQ_A_STEPTIME     4'h5
`define DSQ_A_STATUS       4'h6
`define DSQ_A_SPEED        4'h7
`define DSQ_A_OUTFN        4'h8
`define DSQ_A_FREQ_BASE    5'h10
`define DSQ_BAD_DATA       32'hDEADBEEF
`define DSQ_F_NONE         6'h00
`define DSQ_F_STEP1        6'h01
`define DSQ_F_RESET_NO     6'h05
`define DSQ_F_TIME1        6'h07
`define DSQ_F_TIME2        6'h08
`define DSQ_F_RUN_PROG     6'h0E
`define DSQ_F_PAUSE_PROG   6'h0F
`define DSQ_F_SRC_ACI      6'h15
`define DSQ_F_SRC_AUI      6'h16
`define DSQ_F_STOP_NC      6'h19
`define DSQ_F_STOP_NO      6'h1A
`define DSQ_F_LOCK         6'h1B
`define DSQ_F_PID_OFF      6'h1C
`define DSQ_F_JOG_DIR      6'h1D
`define DSQ_F_RESET_NC     6'h1E
`define DSQ_F_FREQ_SRC2    6'h1F
`define DSQ_F_OPER_SRC2    6'h20
`define DSQ_F_ONE_SHOT     6'h21
`define DSQ_F_PROX         6'h22
`define DSQ_F_SHUT_NO      6'h23
`define DSQ_F_SHUT_NC      6'h24
`endif

// File: rtl/dsq_pkg.sv
// Types shared by the step sequencer block
package dsq_pkg;
  typedef enum logic [2:0] {
    DSQ_MODE_OFF       = 3'h0,
    DSQ_MODE_ONE       = 3'h1,
    DSQ_MODE_CONT      = 3'h2,
    DSQ_MODE_ONE_STEP  = 3'h3,
    DSQ_MODE_CONT_STEP = 3'h4
  } dsq_mode_type;
  typedef enum logic [1:0] {
    DSQ_ST_IDLE  = 2'h0,
    DSQ_ST_RUN   = 2'h1,
    DSQ_ST_DONE  = 2'h2
  } dsq_state_type;
  typedef enum logic [1:0] {
    DSQ_ANA_VOLT = 2'h0,
    DSQ_ANA_CURR = 2'h1,
    DSQ_ANA_AUX  = 2'h2
  } dsq_ana_type;
endpackage

// File: rtl/dsq_top.sv
// Input terminal decoder, debounce and step-speed sequencer with Avalon-MM registers
//
// Notes on behaviour
// R01: Forced stop halts, no fault, needs new run
// R02: Parameter lock rejects all parameter writes
// R03: PID-disable input bypasses PID control
// R04: Jog direction reverse when on, jog only
// R05: Normally-closed reset fires on contact open
// R06: Frequency source two when input on
// R07: Operation source two when input on
// R08: One-shot pulse starts program; stop cancels
// R09: Shutoff coasts motor; restart from zero
// R10: Analog priority voltage, then current, auxiliary
// R11: Two terminals pick accel/decel time 1-4
// R12: Four terminals binary step code, 0=master
// R13: Step frequencies 0 to 40000, default zero
// R14: Debounce delay 1 to 20 two-ms units
// R15: Index: hold speed until sensor, then decel
// R16: Gear, angle, index decel limits and defaults
// R17: Mode 0 off, 1 one, 2 cont, 3/4 stepwise
// R18: Single cycle reruns only after run toggles
// R19: Outputs signal running, step done, program done
// R20: Run-program input steps speed and direction
// R21: Pause input holds a running program
// R22: Level accepted only after stable whole delay
//
// Added by the designer: register access over Avalon-MM and the register addresses.
`include "dsq_cfg.svh"
module dsq_top
  import dsq_pkg::*;
#(
  parameter int N_IN     = 6,
  parameter int N_OUT    = 4,
  parameter int TICK_CYC = `DSQ_TICK_CYC
) (
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic [N_IN-1:0]   term_in,
  input  wire logic              jog_active,
  input  wire logic              run_cmd,
  input  wire logic              stop_cmd,
  output logic                   stop_req,
  output logic                   coast_out,
  output logic                   restart_zero,
  output logic                   fault_reset,
  output logic                   pid_bypass,
  output logic                   jog_reverse,
  output logic                   freq_src2,
  output logic                   oper_src2,
  output logic [1:0]             ana_sel,
  output logic [1:0]             accel_sel,
  output logic [3:0]             step_code,
  output logic [15:0]            speed_cmd,
  output logic                   speed_rev,
  output logic                   index_decel,
  output logic [N_OUT-1:0]       out_term
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [N_IN-1:0] fn_hit(input logic [N_IN*6-1:0] map, input logic [5:0] code);
    for (int k = 0; k < N_IN; k++) begin
      fn_hit[k] = (map[k*6 +: 6] == code);
    end
  endfunction
  function automatic logic any_on(input logic [N_IN-1:0] hit, input logic [N_IN-1:0] lvl);
    any_on = |(hit & lvl);
  endfunction
  function automatic logic any_off(input logic [N_IN-1:0] hit, input logic [N_IN-1:0] lvl);
    any_off = |(hit & ~lvl);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [N_IN*6-1:0]  fn_map_q;
  logic [2:0]         mode_q;
  logic               lock_q;
  logic [4:0]         deb_q;
  logic [10:0]        gear_q;
  logic [11:0]        angle_q;
  logic [13:0]        idx_dec_q;
  logic [15:0]        step_ticks_q;
  logic [15:0]        dir_mask_q;
  logic [N_OUT*6-1:0] out_map_q;
  logic [15:0]        freq_q [1:15];
  logic [N_IN-1:0]    clean_q;
  logic               wr_ok;
  logic               bus_hit;

  // Request taken while waitrequest is high; ack lands on that edge, write one edge later
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end
  // Read data loads on the taking edge so it stands with the ack
  assign bus_hit = avs_read && avs_waitrequest;
  assign wr_ok   = avs_write && !avs_waitrequest && !lock_q; // R02

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      fn_map_q     <= '0;
      mode_q       <= DSQ_MODE_OFF;
      deb_q        <= `DSQ_DEB_RST;
      gear_q       <= `DSQ_GEAR_RST;
      angle_q      <= `DSQ_ANGLE_RST;
      idx_dec_q    <= '0;
      step_ticks_q <= `DSQ_STEP_TICKS_RST;
      dir_mask_q   <= '0;
      out_map_q    <= '0;
    end else if (wr_ok) begin
      if (avs_address == `DSQ_A_CTRL) begin
        if (avs_writedata[2:0] <= 3'h4) begin
          mode_q <= avs_writedata[2:0]; // R17
        end
        if (avs_writedata[12:8] >= `DSQ_DEB_MIN && avs_writedata[12:8] <= `DSQ_DEB_MAX) begin
          deb_q <= avs_writedata[12:8]; // R14
        end
      end else if (avs_address == `DSQ_A_TERMFN0) begin
        fn_map_q[23:0] <= avs_writedata[23:0];
      end else if (avs_address == `DSQ_A_TERMFN1) begin
        fn_map_q[N_IN*6-1:24] <= avs_writedata[N_IN*6-25:0];
      end else if (avs_address == `DSQ_A_MISC) begin
        dir_mask_q <= avs_writedata[15:0];
      end else if (avs_address == `DSQ_A_INDEX) begin
        if (avs_writedata[10:0] >= `DSQ_GEAR_MIN && avs_writedata[10:0] <= `DSQ_GEAR_MAX) begin
          gear_q <= avs_writedata[10:0]; // R16
        end
        if (avs_writedata[27:16] <= `DSQ_ANGLE_MAX) begin
          angle_q <= avs_writedata[27:16]; // R16
        end
      end else if (avs_address == `DSQ_A_STEPTIME) begin
        step_ticks_q <= avs_writedata[15:0];
        if (avs_writedata[29:16] <= `DSQ_IDXDEC_MAX) begin
          idx_dec_q <= avs_writedata[29:16]; // R16
        end
      end else if (avs_address == `DSQ_A_OUTFN) begin
        out_map_q <= avs_writedata[N_OUT*6-1:0];
      end
    end
  end

  // Frequency table: word written at the SPEED address, step number in data bits 19:16
  generate
    for (genvar s = 1; s < 16; s++) begin : g_freq
      always_ff @(posedge mclk) begin
        if (!rst_b) begin
          freq_q[s] <= '0; // R13
        end else if (wr_ok && avs_address == `DSQ_A_SPEED && avs_writedata[19:16] == 4'(s)
                     && avs_writedata[15:0] <= `DSQ_FREQ_MAX) begin
          freq_q[s] <= avs_writedata[15:0]; // R13
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Debounce: one shared 2 ms tick keeps the per-input counters small
  logic [$clog2(TICK_CYC)-1:0] tick_cnt_q;
  logic                        tick;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      tick_cnt_q <= '0;
    end else if (tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end
  assign tick = (tick_cnt_q == ($clog2(TICK_CYC))'(TICK_CYC - 1)); // R22

  generate
    for (genvar i = 0; i < N_IN; i++) begin : g_deb
      logic [4:0] cnt_q;
      always_ff @(posedge mclk) begin
        if (!rst_b) begin
          cnt_q      <= '0;
          clean_q[i] <= 1'b0;
        end else if (term_in[i] == clean_q[i]) begin
          cnt_q <= '0; // R22
        end else if (tick) begin
          // First tick starts mid-period, so wait one more for a whole delay
          if (cnt_q >= deb_q) begin
            clean_q[i] <= term_in[i]; // R14
            cnt_q      <= '0;
          end else begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  logic            stop_nc, stop_no, shut_nc, shut_no, shut_act, shut_prev_q;
  logic            rst_no, rst_nc, rst_no_prev_q, rst_nc_prev_q;
  logic            run_lvl, run_prev_q, one_shot, one_prev_q, pause, prox;
  logic            forced_stop, latch_stop_q, prox_wait_q, prox_used;
  always_comb begin
    stop_nc  = any_off(fn_hit(fn_map_q, `DSQ_F_STOP_NC), clean_q);
    stop_no  = any_on(fn_hit(fn_map_q, `DSQ_F_STOP_NO), clean_q);
    shut_nc  = any_off(fn_hit(fn_map_q, `DSQ_F_SHUT_NC), clean_q);
    shut_no  = any_on(fn_hit(fn_map_q, `DSQ_F_SHUT_NO), clean_q);
    shut_act = shut_nc || shut_no;
    rst_no   = any_on(fn_hit(fn_map_q, `DSQ_F_RESET_NO), clean_q);
    rst_nc   = any_off(fn_hit(fn_map_q, `DSQ_F_RESET_NC), clean_q);
    run_lvl  = any_on(fn_hit(fn_map_q, `DSQ_F_RUN_PROG), clean_q);
    one_shot = any_on(fn_hit(fn_map_q, `DSQ_F_ONE_SHOT), clean_q);
    pause    = any_on(fn_hit(fn_map_q, `DSQ_F_PAUSE_PROG), clean_q);
    prox     = any_on(fn_hit(fn_map_q, `DSQ_F_PROX), clean_q);
    forced_stop = stop_nc || stop_no;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      shut_prev_q   <= 1'b0;
      rst_no_prev_q <= 1'b0;
      rst_nc_prev_q <= 1'b0;
      run_prev_q    <= 1'b0;
      one_prev_q    <= 1'b0;
      latch_stop_q  <= 1'b0;
      lock_q        <= 1'b0;
    end else begin
      shut_prev_q   <= shut_act;
      rst_no_prev_q <= rst_no;
      rst_nc_prev_q <= rst_nc;
      run_prev_q    <= run_lvl;
      one_prev_q    <= one_shot;
      lock_q        <= any_on(fn_hit(fn_map_q, `DSQ_F_LOCK), clean_q); // R02
      if (forced_stop) begin
        latch_stop_q <= 1'b1; // R01
      end else if (run_cmd) begin
        latch_stop_q <= 1'b0; // R01
      end
    end
  end

  // Terminal-driven outputs, all registered
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      stop_req     <= 1'b0;
      coast_out    <= 1'b0;
      restart_zero <= 1'b0;
      fault_reset  <= 1'b0;
      pid_bypass   <= 1'b0;
      jog_reverse  <= 1'b0;
      freq_src2    <= 1'b0;
      oper_src2    <= 1'b0;
      ana_sel      <= DSQ_ANA_VOLT;
      accel_sel    <= 2'h0;
      step_code    <= 4'h0;
    end else begin
      stop_req     <= latch_stop_q || forced_stop || (stop_cmd && (!prox_used || index_decel)); // R01 R15
      coast_out    <= shut_act; // R09
      restart_zero <= shut_prev_q && !shut_act; // R09
      fault_reset  <= (rst_no && !rst_no_prev_q) || (rst_nc && !rst_nc_prev_q); // R05
      pid_bypass   <= any_on(fn_hit(fn_map_q, `DSQ_F_PID_OFF), clean_q); // R03
      jog_reverse  <= jog_active && any_on(fn_hit(fn_map_q, `DSQ_F_JOG_DIR), clean_q); // R04
      freq_src2    <= any_on(fn_hit(fn_map_q, `DSQ_F_FREQ_SRC2), clean_q); // R06
      oper_src2    <= any_on(fn_hit(fn_map_q, `DSQ_F_OPER_SRC2), clean_q); // R07
      if (any_on(fn_hit(fn_map_q, `DSQ_F_SRC_ACI), clean_q)
          && any_on(fn_hit(fn_map_q, `DSQ_F_SRC_AUI), clean_q)) begin
        ana_sel <= DSQ_ANA_VOLT; // R10
      end else if (any_on(fn_hit(fn_map_q, `DSQ_F_SRC_ACI), clean_q)) begin
        ana_sel <= DSQ_ANA_CURR; // R10
      end else if (any_on(fn_hit(fn_map_q, `DSQ_F_SRC_AUI), clean_q)) begin
        ana_sel <= DSQ_ANA_AUX; // R10
      end else begin
        ana_sel <= DSQ_ANA_VOLT;
      end
      accel_sel <= {any_on(fn_hit(fn_map_q, `DSQ_F_TIME2), clean_q),
                    any_on(fn_hit(fn_map_q, `DSQ_F_TIME1), clean_q)}; // R11
      for (int b = 0; b < 4; b++) begin
        step_code[b] <= any_on(fn_hit(fn_map_q, `DSQ_F_STEP1 + 6'(b)), clean_q); // R12
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Index stop: hold speed after stop until the sensor fires, then decelerate
  assign prox_used = |fn_hit(fn_map_q, `DSQ_F_PROX);
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      prox_wait_q <= 1'b0;
      index_decel <= 1'b0;
    end else if (!prox_used || run_cmd) begin
      prox_wait_q <= 1'b0;
      index_decel <= 1'b0;
    end else if (stop_cmd && !prox_wait_q && !index_decel) begin
      prox_wait_q <= 1'b1; // R15
    end else if (prox_wait_q && prox) begin
      prox_wait_q <= 1'b0;
      index_decel <= 1'b1; // R15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Step sequencer
  dsq_state_type st_q;
  logic [3:0]    step_q;
  logic [15:0]   dwell_q;
  logic          step_pulse_q, prog_done_q, armed_q, one_run_q;
  logic          start_ev, cancel, stepwise, cont;
  assign stepwise = (mode_q == DSQ_MODE_ONE_STEP) || (mode_q == DSQ_MODE_CONT_STEP);
  assign cont     = (mode_q == DSQ_MODE_CONT) || (mode_q == DSQ_MODE_CONT_STEP);
  assign start_ev = (run_lvl && armed_q) || (one_shot && !one_prev_q); // R08
  assign cancel   = (mode_q == DSQ_MODE_OFF) || forced_stop || (one_run_q && stop_cmd)
                    || (!one_run_q && !run_lvl); // R08

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_q         <= DSQ_ST_IDLE;
      step_q       <= 4'h0;
      dwell_q      <= '0;
      step_pulse_q <= 1'b0;
      prog_done_q  <= 1'b0;
      armed_q      <= 1'b1;
      one_run_q    <= 1'b0;
    end else begin
      step_pulse_q <= 1'b0;
      if (!run_lvl) begin
        armed_q <= 1'b1; // R18
      end
      case (st_q)
        DSQ_ST_IDLE: begin
          if (mode_q != DSQ_MODE_OFF && start_ev && !forced_stop) begin
            st_q        <= DSQ_ST_RUN; // R20
            step_q      <= 4'h1;
            dwell_q     <= '0;
            armed_q     <= 1'b0;
            prog_done_q <= 1'b0;
            one_run_q   <= one_shot && !one_prev_q;
          end
        end
        DSQ_ST_RUN: begin
          if (cancel) begin
            st_q <= DSQ_ST_IDLE; // R08
          end else if (pause) begin
            st_q <= DSQ_ST_RUN; // R21
          end else if (tick) begin
            if (dwell_q + 16'h0001 >= step_ticks_q) begin
              dwell_q      <= '0;
              step_pulse_q <= 1'b1; // R19
              if (step_q == 4'hF) begin
                step_q <= 4'h1;
                if (!cont) begin
                  st_q        <= DSQ_ST_DONE; // R18
                  prog_done_q <= 1'b1; // R19
                end
              end else begin
                step_q <= step_q + 4'h1; // R20
              end
            end else begin
              dwell_q <= dwell_q + 16'h0001;
            end
          end
        end
        DSQ_ST_DONE: begin
          if (!run_lvl && !one_shot) begin
            st_q <= DSQ_ST_IDLE; // R18
          end
        end
        default: st_q <= DSQ_ST_IDLE;
      endcase
    end
  end

  // Speed: sequencer step, else terminal step code; zero while stepwise between steps
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      speed_cmd <= '0;
      speed_rev <= 1'b0;
    end else if (st_q == DSQ_ST_RUN) begin
      speed_cmd <= (stepwise && step_pulse_q) ? 16'h0000 : freq_q[step_q]; // R20
      speed_rev <= dir_mask_q[step_q - 4'h1]; // R20
    end else if (step_code != 4'h0) begin
      speed_cmd <= freq_q[step_code]; // R12
      speed_rev <= 1'b0;
    end else begin
      speed_cmd <= '0;
      speed_rev <= 1'b0;
    end
  end

  // Programmable outputs
  generate
    for (genvar o = 0; o < N_OUT; o++) begin : g_out
      always_ff @(posedge mclk) begin
        if (!rst_b) begin
          out_term[o] <= 1'b0;
        end else begin
          out_term[o] <= (out_map_q[o*6 +: 6] == `DSQ_OUT_RUNNING   && st_q == DSQ_ST_RUN)
                      || (out_map_q[o*6 +: 6] == `DSQ_OUT_STEP_DONE && step_pulse_q)
                      || (out_map_q[o*6 +: 6] == `DSQ_OUT_PROG_DONE && prog_done_q); // R19
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      avs_readdata <= '0;
    end else if (bus_hit) begin
      if (avs_address == `DSQ_A_CTRL) begin
        avs_readdata <= {19'h0, deb_q, 5'h0, mode_q};
      end else if (avs_address == `DSQ_A_TERMFN0) begin
        avs_readdata <= {8'h0, fn_map_q[23:0]};
      end else if (avs_address == `DSQ_A_TERMFN1) begin
        avs_readdata <= 32'(fn_map_q[N_IN*6-1:24]);
      end else if (avs_address == `DSQ_A_MISC) begin
        avs_readdata <= {16'h0, dir_mask_q};
      end else if (avs_address == `DSQ_A_INDEX) begin
        avs_readdata <= {4'h0, angle_q, 5'h0, gear_q};
      end else if (avs_address == `DSQ_A_STEPTIME) begin
        avs_readdata <= {2'h0, idx_dec_q, step_ticks_q};
      end else if (avs_address == `DSQ_A_STATUS) begin
        avs_readdata <= {11'h0, 2'(st_q), step_q, prog_done_q, lock_q, prox_wait_q, index_decel,
                         latch_stop_q, 2'h0, 8'(clean_q)};
      end else if (avs_address == `DSQ_A_SPEED) begin
        avs_readdata <= {16'h0, speed_cmd};
      end else if (avs_address == `DSQ_A_OUTFN) begin
        avs_readdata <= 32'(out_map_q);
      end else begin
        avs_readdata <= `DSQ_BAD_DATA;
      end
    end
  end
endmodule

// File: bench/dsq_asserts.sv
// Port checks for the terminal decoder and step sequencer
module dsq_asserts (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic        coast_out,
  input wire logic        restart_zero,
  input wire logic        fault_reset,
  input wire logic        jog_active,
  input wire logic        jog_reverse,
  input wire logic [1:0]  ana_sel,
  input wire logic [15:0] speed_cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////
  ack_short_a : assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("acknowledge held too long");
  ack_cause_a : assert property ($fell(avs_waitrequest) |-> $past(avs_read) || $past(avs_write))
    else $error("acknowledge without request");
  fault_pulse_a : assert property (fault_reset |=> !fault_reset)
    else $error("fault reset longer than one cycle");
  restart_pulse_a : assert property (restart_zero |=> !restart_zero)
    else $error("restart pulse too long");
  restart_cause_a : assert property ($rose(restart_zero) |-> !coast_out && ($past(coast_out) || $past(coast_out, 2)))
    else $error("restart without shutoff release");
  jog_gate_a : assert property (!jog_active [*2] |-> !jog_reverse)
    else $error("jog reverse without jog");
  ana_code_a : assert property (ana_sel != 2'h3)
    else $error("bad analog source code");
  speed_limit_a : assert property (speed_cmd <= 16'h9C40)
    else $error("speed above limit");
  ////////////////////////////////////////////////////////////
  cover property ($rose(coast_out));
  cover property (fault_reset);
  cover property ($fell(avs_waitrequest) && $past(avs_write));
endmodule

bind dsq_top dsq_asserts chk_u (.mclk(mclk), .rst_b(rst_b), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .coast_out(coast_out), .restart_zero(restart_zero),
  .fault_reset(fault_reset), .jog_active(jog_active), .jog_reverse(jog_reverse), .ana_sel(ana_sel),
  .speed_cmd(speed_cmd));

// File: bench/dsq_contacts.sv
// Chattering contact model for the six input terminals
module dsq_contacts (
  input  wire logic       mclk,
  input  wire logic [5:0] want,
  output logic      [5:0] term_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] old_q = 6'h00;
  logic [5:0] now_q = 6'h00;
  logic [2:0] cnt_q = 3'h0;
  // Chatter lasts under one tick, so a sound debounce never passes it
  always @(posedge mclk) begin
    if (want !== now_q) begin
      old_q <= now_q;
      now_q <= want;
      cnt_q <= 3'h5;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
    end
  end
  assign term_in = cnt_q[0] ? old_q : now_q;
endmodule

// File: bench/dsq_top_tb.sv
// Self-checking bench for the terminal decoder and step sequencer
`include "dsq_cfg.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (g), (e)); end end
module dsq_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic        avs_waitrequest, stop_req, coast_out, restart_zero, fault_reset, pid_bypass;
  logic        jog_reverse, freq_src2, oper_src2, speed_rev, index_decel;
  logic [5:0]  want = 6'h00;
  logic [5:0]  term_in;
  logic        jog_active = 1'b0;
  logic        run_cmd = 1'b0;
  logic        stop_cmd = 1'b0;
  logic [1:0]  ana_sel, accel_sel;
  logic [3:0]  step_code, out_term;
  logic [15:0] speed_cmd;
  int          bad_count = 0, checks = 0, n_fault = 0, n_rz = 0;
  always #5 mclk = ~mclk;
  ////////////////////////////////////////////////////////////
  dsq_top #(.N_IN(6), .N_OUT(4), .TICK_CYC(10)) dut_u (.mclk(mclk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .term_in(term_in),
    .jog_active(jog_active), .run_cmd(run_cmd), .stop_cmd(stop_cmd), .stop_req(stop_req),
    .coast_out(coast_out), .restart_zero(restart_zero), .fault_reset(fault_reset),
    .pid_bypass(pid_bypass), .jog_reverse(jog_reverse), .freq_src2(freq_src2), .oper_src2(oper_src2),
    .ana_sel(ana_sel), .accel_sel(accel_sel), .step_code(step_code), .speed_cmd(speed_cmd),
    .speed_rev(speed_rev), .index_decel(index_decel), .out_term(out_term));
  dsq_contacts sw_u (.mclk(mclk), .want(want), .term_in(term_in));
  always @(posedge mclk) begin
    if (fault_reset === 1'b1) n_fault++;
    if (restart_zero === 1'b1) n_rz++;
  end
  ////////////////////////////////////////////////////////////
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    // Only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic term(input logic [5:0] v);
    @(posedge mclk);
    want <= v;
    repeat (80) @(posedge mclk);
  endtask
  task automatic wait_out(input int k, input logic lv, input int lim);
    int n;
    n = 0;
    while (out_term[k] !== lv && n < lim) begin
      @(posedge mclk);
      n++;
    end
    `CHK(out_term[k], lv)
  endtask
  task automatic stop_test;
    $display("bad_count=%0d checks=%0d", bad_count, checks);
    if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    `CHK(({stop_req, coast_out, fault_reset, out_term}), 7'h00)
    bus(1'b0, `DSQ_A_CTRL, 32'h0);
    `CHK(rd, 32'h00000100)
    bus(1'b0, `DSQ_A_INDEX, 32'h0);
    `CHK(rd, 32'h070800C8)
    bus(1'b0, 4'hF, 32'h0);
    `CHK(rd, 32'hDEADBEEF)
  endtask
  task automatic t_select;
    bus(1'b1, `DSQ_A_TERMFN0, {8'h00, `DSQ_F_JOG_DIR, `DSQ_F_PID_OFF, `DSQ_F_TIME2, `DSQ_F_TIME1});
    bus(1'b1, `DSQ_A_TERMFN1, {20'h0, `DSQ_F_OPER_SRC2, `DSQ_F_FREQ_SRC2});
    for (int i = 0; i < 4; i++) begin
      term(i[5:0]);
      `CHK(accel_sel, i[1:0])
    end
    term(6'h3C);
    `CHK(({pid_bypass, jog_reverse, freq_src2, oper_src2}), 4'hB)
    jog_active <= 1'b1;
    repeat (4) @(posedge mclk);
    `CHK(jog_reverse, 1'b1)
    term(6'h00);
    `CHK(({pid_bypass, jog_reverse, freq_src2, oper_src2}), 4'h0)
    jog_active <= 1'b0;
  endtask
  task automatic t_codes;
    bus(1'b1, `DSQ_A_TERMFN0, {8'h00, 6'h04, 6'h03, 6'h02, `DSQ_F_STEP1});
    for (int i = 0; i < 16; i += 5) begin
      term(i[5:0]);
      `CHK(step_code, i[3:0])
    end
    bus(1'b1, `DSQ_A_TERMFN0, {20'h0, `DSQ_F_SRC_AUI, `DSQ_F_SRC_ACI});
    for (int i = 3; i >= 0; i--) begin
      term(i[5:0]);
      `CHK(ana_sel, (i == 3) ? 2'h0 : i[1:0])
    end
  endtask
  task automatic t_lock;
    bus(1'b1, `DSQ_A_TERMFN1, {20'h0, `DSQ_F_LOCK, 6'h00});
    term(6'h20);
    bus(1'b1, `DSQ_A_CTRL, 32'h00000200);
    bus(1'b0, `DSQ_A_CTRL, 32'h0);
    `CHK(rd, 32'h00000100)
    term(6'h00);
    bus(1'b1, `DSQ_A_CTRL, 32'h00000200);
    bus(1'b1, `DSQ_A_CTRL, 32'h00001500);
    bus(1'b0, `DSQ_A_CTRL, 32'h0);
    `CHK(rd, 32'h00000200)
  endtask
  task automatic t_stop;
    int n;
    bus(1'b1, `DSQ_A_TERMFN1, {20'h0, `DSQ_F_RESET_NC, `DSQ_F_STOP_NO});
    term(6'h20);
    n = n_fault;
    term(6'h30);
    `CHK(stop_req, 1'b1)
    term(6'h20);
    `CHK(stop_req, 1'b1)
    `CHK(n_fault, n)
    run_cmd <= 1'b1;
    @(posedge mclk);
    run_cmd <= 1'b0;
    repeat (4) @(posedge mclk);
    `CHK(stop_req, 1'b0)
    term(6'h00);
    `CHK(n_fault, n + 1)
  endtask
  task automatic t_shut;
    int n;
    bus(1'b1, `DSQ_A_TERMFN0, {26'h0, `DSQ_F_SHUT_NO});
    n = n_rz;
    term(6'h01);
    `CHK(coast_out, 1'b1)
    term(6'h00);
    `CHK(coast_out, 1'b0)
    `CHK(n_rz, n + 1)
  endtask
  task automatic t_prog;
    bus(1'b1, `DSQ_A_STEPTIME, 32'h00000002);
    bus(1'b1, `DSQ_A_SPEED, 32'h00011388);
    bus(1'b1, `DSQ_A_OUTFN, 32'h0000C2CA);
    bus(1'b1, `DSQ_A_TERMFN0, {20'h0, `DSQ_F_STEP1, `DSQ_F_RUN_PROG});
    bus(1'b1, `DSQ_A_CTRL, 32'h00000201);
    term(6'h02);
    `CHK(speed_cmd, 16'h1388)
    term(6'h01);
    wait_out(0, 1'b1, 100);
    wait_out(2, 1'b1, 2000);
    `CHK(out_term[0], 1'b0)
    repeat (100) @(posedge mclk);
    `CHK(out_term[0], 1'b0)
    term(6'h00);
    term(6'h01);
    wait_out(0, 1'b1, 100);
  endtask
  task automatic t_index;
    term(6'h00);
    bus(1'b1, `DSQ_A_TERMFN0, {26'h0, `DSQ_F_PROX});
    stop_cmd <= 1'b1;
    repeat (4) @(posedge mclk);
    `CHK(({stop_req, index_decel}), 2'h0)
    term(6'h01);
    `CHK(({stop_req, index_decel}), 2'h3)
    stop_cmd <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset;
    t_select;
    t_codes;
    t_lock;
    t_stop;
    t_shut;
    t_prog;
    t_index;
    stop_test;
  end
  initial begin
    #300000;
    bad_count++;
    stop_test;
  end
endmodule
